// ### core/synth_freq_pkg.sv
// Constants for the carrier synthesizer frequency control block.
// Assumes a 40 MHz system clock and a 10 MHz synthesizer reference.
package synth_freq_pkg;

  // Register addresses on the host register port.
  localparam logic [6:0] ADDR_OFFSET_LOW    = 7'h73;
  localparam logic [6:0] ADDR_OFFSET_HIGH   = 7'h74;
  localparam logic [6:0] ADDR_BAND_SELECT   = 7'h75;
  localparam logic [6:0] ADDR_FRACTION_HIGH = 7'h76;
  localparam logic [6:0] ADDR_FRACTION_LOW  = 7'h77;

  // Reset values.
  localparam logic [7:0] RST_OFFSET_LOW    = 8'h00;
  localparam logic [7:0] RST_OFFSET_HIGH   = 8'h00;
  localparam logic [7:0] RST_BAND_SELECT   = 8'h35;
  localparam logic [7:0] RST_FRACTION_HIGH = 8'hbb;
  localparam logic [7:0] RST_FRACTION_LOW  = 8'h80;

  // Field positions in the band select and offset high registers.
  localparam int BAND_HIGH_BIT  = 5;
  localparam int BAND_FIELD_TOP = 4;
  localparam int OFFSET_HI_TOP  = 1;

  // Divider arithmetic.
  localparam logic [4:0]  BAND_FIELD_MAX = 5'h17;
  localparam logic [6:0]  INT_BASE       = 7'h18;
  localparam logic [16:0] FRAC_MODULUS   = 17'h0fa00;

  // Clock rates and the reference enable divider.
  localparam int CLK_MHZ = 40;
  localparam int REF_MHZ = 10;
  localparam int REF_DIV = CLK_MHZ / REF_MHZ;

  // Sequencer phase times in microseconds; bias plus calibration
  // plus loop settling add up to 200 us.
  localparam int BIAS_US = 20;
  localparam int CAL_US  = 80;
  localparam int LOOP_US = 100;
  localparam logic [11:0] BIAS_CYCLES = 12'(BIAS_US * CLK_MHZ);
  localparam logic [11:0] CAL_CYCLES  = 12'(CAL_US * CLK_MHZ);
  localparam logic [11:0] LOOP_CYCLES = 12'(LOOP_US * CLK_MHZ);

  // Synthesizer sequencer states.
  typedef enum logic [2:0] {
    SEQ_OFF    = 3'b000,
    SEQ_BIAS   = 3'b001,
    SEQ_CAL    = 3'b010,
    SEQ_LOOP   = 3'b011,
    SEQ_LOCKED = 3'b100
  } seq_state_type;

endpackage

// ### core/synth_frequency_control.sv
// Digital frequency control of the fractional-N carrier synthesizer.
// Assumes a synchronous byte-wide register port driven by the host
// interface logic, and synchronous transmit data and mode inputs.
//
// Functional notes
// - Calibrate on every frequency change and power-up unless fast option set.
// - Loop settling lasts 100 us by default.
// - Bias, calibration and settling total 200 us.
// - Fast option skips bias and calibration phases.
// - Host sets target; sequencer does every step.
// - Third order modulator, 10 MHz, modulo 64000.
// - Transmit bit steers fractional divider value.
// - Fraction combines carrier, offset and deviation.
// - Integer ratio is band field plus 24.
// - High band bit controls output halving stage.
// - Band field above 23 stored as 23.
// - Band steps 10 MHz low, 20 MHz high.
// - Signed offset trims carrier for crystal error.
// - Offset is ten-bit signed, hbsel-scaled steps.
// - Deviation step is 625 Hz in both bands.
`timescale 1ns/1ps

module synth_frequency_control
  import synth_freq_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Host register port.
  input  wire logic       reg_write_i,
  input  wire logic       reg_read_i,
  input  wire logic [6:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Target mode and sequencer option.
  input  wire logic       synth_enable_i,
  input  wire logic       fast_turn_i,
  // Modulation inputs.
  input  wire logic       fsk_enable_i,
  input  wire logic       tx_data_i,
  input  wire logic [8:0] deviation_word_i,
  // Sequencer outputs to the analog synthesizer.
  output logic            bias_settle_phase_o,
  output logic            vco_cal_o,
  output logic            loop_settle_phase_o,
  output logic            synth_locked_o,
  // Divider control outputs.
  output logic            ref_tick_o,
  output logic      [6:0] int_ratio_o,
  output logic     [15:0] frac_value_o,
  output logic      [6:0] div_ratio_o,
  output logic            high_band_o,
  output logic            halve_output_o
);

  // Stored configuration registers.
  logic [7:0]    frequency_offset_low;   // Offset word bits 7..0.
  logic [7:0]    frequency_offset_high;  // Offset word bits 9..8.
  logic [7:0]    band_select;            // Band bits and band field.
  logic [7:0]    carrier_fraction_high;  // Carrier fraction bits 15..8.
  logic [7:0]    carrier_fraction_low;   // Carrier fraction bits 7..0.
  // Sequencer state.
  seq_state_type state;                  // Current phase.
  logic [11:0]   phase_count;            // Cycles left in the phase.
  logic          enable_seen;            // Enable level last cycle.
  logic          freq_write;             // A frequency register write.
  // Reference tick divider.
  logic [1:0]    ref_count;              // Counts clocks per reference.
  // Fraction arithmetic.
  logic [4:0]    integer_band_field;     // Clamped band field.
  logic [15:0]   carrier_fraction_word;  // Nominal carrier fraction.
  logic [9:0]    offset_word;            // Signed offset word.
  logic signed [19:0] dev_units;         // Deviation in fraction steps.
  logic signed [19:0] frac_sum;          // Raw combined fraction.
  logic [16:0]   next_frac;              // Fraction within the modulus.
  logic [6:0]    next_int;               // Integer ratio after carry.
  // Modulator accumulators and carries.
  logic [15:0]   acc1;
  logic [15:0]   acc2;
  logic [15:0]   acc3;
  logic [16:0]   add1;
  logic [16:0]   add2;
  logic [16:0]   add3;
  logic          c2_d;
  logic          c3_d;
  logic          c3_dd;
  logic signed [3:0] dsm_out;            // Modulator divider step.
  // Modulo 64000 addition; the top bit of the result is the carry.
  function automatic logic [16:0] mod_add(input logic [15:0] a,
                                          input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    mod_add = (s >= FRAC_MODULUS) ? {1'b1, 16'(s - FRAC_MODULUS)}
                                  : {1'b0, s[15:0]};
  endfunction
  assign integer_band_field    = band_select[BAND_FIELD_TOP:0];
  assign carrier_fraction_word = {carrier_fraction_high,
                                  carrier_fraction_low};
  assign offset_word = {frequency_offset_high[OFFSET_HI_TOP:0],
                        frequency_offset_low};
  assign freq_write  = reg_write_i &&
                       (reg_addr_i >= ADDR_OFFSET_LOW) &&
                       (reg_addr_i <= ADDR_FRACTION_LOW);
  // Register writes; band field is clamped at write time.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      frequency_offset_low  <= RST_OFFSET_LOW;
      frequency_offset_high <= RST_OFFSET_HIGH;
      band_select           <= RST_BAND_SELECT;
      carrier_fraction_high <= RST_FRACTION_HIGH;
      carrier_fraction_low  <= RST_FRACTION_LOW;
    end else if (reg_write_i) begin
      case (reg_addr_i)
        ADDR_OFFSET_LOW:    frequency_offset_low  <= reg_wdata_i;
        ADDR_OFFSET_HIGH:   frequency_offset_high <= reg_wdata_i;
        ADDR_BAND_SELECT: begin
          if (reg_wdata_i[BAND_FIELD_TOP:0] > BAND_FIELD_MAX) begin
            band_select <= {reg_wdata_i[7:BAND_FIELD_TOP+1],
                            BAND_FIELD_MAX};
          end else begin
            band_select <= reg_wdata_i;
          end
        end
        ADDR_FRACTION_HIGH: carrier_fraction_high <= reg_wdata_i;
        ADDR_FRACTION_LOW:  carrier_fraction_low  <= reg_wdata_i;
        default: begin
          // Other addresses belong to other blocks.
        end
      endcase
    end
  end

  // Read data is registered and valid the cycle after the strobe.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_read_i) begin
      case (reg_addr_i)
        ADDR_OFFSET_LOW:    reg_rdata_o <= frequency_offset_low;
        ADDR_OFFSET_HIGH:   reg_rdata_o <= frequency_offset_high;
        ADDR_BAND_SELECT:   reg_rdata_o <= band_select;
        ADDR_FRACTION_HIGH: reg_rdata_o <= carrier_fraction_high;
        ADDR_FRACTION_LOW:  reg_rdata_o <= carrier_fraction_low;
        default:            reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Enable level history, used to spot a synthesizer power-up.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      enable_seen <= 1'b0;
    end else begin
      enable_seen <= synth_enable_i;
    end
  end

  // Settling sequencer. The host only sets the enable level; every
  // phase after that runs on its own timers. A new frequency write
  // during any phase restarts the whole sequence, so the lock flag
  // never covers a stale setting.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state       <= SEQ_OFF;
      phase_count <= 12'h000;
    end else if (!synth_enable_i) begin
      state       <= SEQ_OFF;
      phase_count <= 12'h000;
    end else if ((!enable_seen) || freq_write) begin
      if (fast_turn_i) begin
        state       <= SEQ_LOOP;
        phase_count <= LOOP_CYCLES - 12'h001;
      end else begin
        state       <= SEQ_BIAS;
        phase_count <= BIAS_CYCLES - 12'h001;
      end
    end else begin
      case (state)
        SEQ_BIAS: begin
          if (phase_count == 12'h000) begin
            state       <= SEQ_CAL;
            phase_count <= CAL_CYCLES - 12'h001;
          end else begin
            phase_count <= phase_count - 12'h001;
          end
        end
        SEQ_CAL: begin
          if (phase_count == 12'h000) begin
            state       <= SEQ_LOOP;
            phase_count <= LOOP_CYCLES - 12'h001;
          end else begin
            phase_count <= phase_count - 12'h001;
          end
        end
        SEQ_LOOP: begin
          if (phase_count == 12'h000) begin
            state <= SEQ_LOCKED;
          end else begin
            phase_count <= phase_count - 12'h001;
          end
        end
        SEQ_LOCKED: begin
          // Holds until a new frequency or a disable.
          state <= SEQ_LOCKED;
        end
        default: begin
          // The off state waits here; power-up is caught above.
          state <= SEQ_OFF;
        end
      endcase
    end
  end

  assign bias_settle_phase_o = (state == SEQ_BIAS);
  assign vco_cal_o           = (state == SEQ_CAL);
  assign loop_settle_phase_o = (state == SEQ_LOOP);
  assign synth_locked_o      = (state == SEQ_LOCKED);

  // Divide the 40 MHz clock down to a 10 MHz reference enable.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_count <= 2'h0;
    end else if (ref_count == 2'(REF_DIV - 1)) begin
      ref_count <= 2'h0;
    end else begin
      ref_count <= ref_count + 2'h1;
    end
  end
  assign ref_tick_o = (ref_count == 2'(REF_DIV - 1));

  // Combine the three fraction sources in units of one carrier step,
  // which is 156.25 Hz times (hbsel + 1). The offset uses that unit
  // as is; a deviation step is 625 Hz in either band, so it is four
  // carrier steps in low band and two in high band.
  always_comb begin
    if (band_select[BAND_HIGH_BIT]) begin
      dev_units = 20'(signed'({11'h000, deviation_word_i}) <<< 1);
    end else begin
      dev_units = 20'(signed'({11'h000, deviation_word_i}) <<< 2);
    end
    frac_sum = signed'({4'h0, carrier_fraction_word}) +
               20'(signed'(offset_word));
    if (fsk_enable_i) begin
      if (tx_data_i) begin
        frac_sum = frac_sum + dev_units;
      end else begin
        frac_sum = frac_sum - dev_units;
      end
    end
    next_int = {2'b00, integer_band_field} + INT_BASE;
    // A sum outside the modulus borrows from or carries into the
    // integer ratio, so the total ratio stays continuous.
    if (frac_sum < 20'sd0) begin
      next_frac = 17'(frac_sum + signed'({3'b000, FRAC_MODULUS}));
      next_int  = next_int - 7'h01;
    end else if (frac_sum >= signed'({3'b000, FRAC_MODULUS})) begin
      next_frac = 17'(frac_sum - signed'({3'b000, FRAC_MODULUS}));
      next_int  = next_int + 7'h01;
    end else begin
      next_frac = 17'(frac_sum);
    end
  end

  // Three cascaded first order stages; only the stage sums are
  // combinational, the accumulators move on the reference enable.
  assign add1 = mod_add(acc1, next_frac[15:0]);
  assign add2 = mod_add(acc2, add1[15:0]);
  assign add3 = mod_add(acc3, add2[15:0]);

  // third order, 10 MHz, modulo 64000
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc1    <= 16'h0000;
      acc2    <= 16'h0000;
      acc3    <= 16'h0000;
      c2_d    <= 1'b0;
      c3_d    <= 1'b0;
      c3_dd   <= 1'b0;
      dsm_out <= 4'sh0;
    end else if (ref_tick_o) begin
      acc1    <= add1[15:0];
      acc2    <= add2[15:0];
      acc3    <= add3[15:0];
      c2_d    <= add2[16];
      c3_d    <= add3[16];
      c3_dd   <= c3_d;
      // Noise-shaped step: c1 + (c2 - c2') + (c3 - 2c3' + c3'').
      dsm_out <= signed'({3'b000, add1[16]}) +
                 signed'({3'b000, add2[16]}) -
                 signed'({3'b000, c2_d}) +
                 signed'({3'b000, add3[16]}) -
                 signed'({2'b00, c3_d, 1'b0}) +
                 signed'({3'b000, c3_dd});
    end
  end

  // Divider control words, updated once per reference period.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_ratio_o  <= INT_BASE;
      frac_value_o <= 16'h0000;
      div_ratio_o  <= INT_BASE;
    end else if (ref_tick_o) begin
      int_ratio_o  <= next_int;
      frac_value_o <= next_frac[15:0];
      div_ratio_o  <= 7'(signed'(next_int) + 7'(dsm_out));
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      high_band_o    <= RST_BAND_SELECT[BAND_HIGH_BIT];
      halve_output_o <= !RST_BAND_SELECT[BAND_HIGH_BIT];
    end else begin
      high_band_o    <= band_select[BAND_HIGH_BIT];
      halve_output_o <= !band_select[BAND_HIGH_BIT];
    end
  end

endmodule // synth_frequency_control

// ### verif/synth_frequency_control_chk.sv
// Port assertions for the synthesizer frequency control block.
// Assumes one clock domain with an active-high asynchronous reset.
`timescale 1ns/1ps

module synth_frequency_control_chk (
  // Clock, reset and stimulus.
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        reg_write_i,
  input wire logic  [6:0] reg_addr_i,
  input wire logic        synth_enable_i,
  input wire logic        fast_turn_i,
  // Watched outputs.
  input wire logic        bias_settle_phase_o,
  input wire logic        vco_cal_o,
  input wire logic        loop_settle_phase_o,
  input wire logic        synth_locked_o,
  input wire logic        ref_tick_o,
  input wire logic  [6:0] int_ratio_o,
  input wire logic [15:0] frac_value_o,
  input wire logic  [6:0] div_ratio_o,
  input wire logic        high_band_o,
  input wire logic        halve_output_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [11:0] bias_cnt;  // Cycles in the running bias phase.
  logic [11:0] loop_cnt;  // Cycles in the running loop phase.
  logic        freq_wr;   // Write to a frequency register.
  assign freq_wr = reg_write_i && reg_addr_i >= 7'h73 && reg_addr_i <= 7'h77;

  // A restart clears the counts, since the phase stays high across it.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bias_cnt <= 12'h000;
      loop_cnt <= 12'h000;
    end else if (synth_enable_i && freq_wr) begin
      bias_cnt <= 12'h000;
      loop_cnt <= 12'h000;
    end else begin
      bias_cnt <= bias_settle_phase_o ? bias_cnt + 12'h001 : 12'h000;
      loop_cnt <= loop_settle_phase_o ? loop_cnt + 12'h001 : 12'h000;
    end
  end

  AST_ONE_PHASE: assert property ($onehot0({bias_settle_phase_o,
    vco_cal_o, loop_settle_phase_o, synth_locked_o})) else $error("phases");
  AST_ENABLE_START: assert property ($rose(synth_enable_i) |=>
    bias_settle_phase_o || loop_settle_phase_o) else $error("no start");
  AST_FAST_SKIP: assert property ($rose(synth_enable_i) && fast_turn_i
    |=> loop_settle_phase_o) else $error("fast start");
  AST_OFF: assert property (!synth_enable_i |=> !(bias_settle_phase_o
    || vco_cal_o || loop_settle_phase_o || synth_locked_o)) else $error("off");
  AST_RESTART: assert property (synth_enable_i && freq_wr |=>
    bias_settle_phase_o || loop_settle_phase_o) else $error("no restart");
  AST_BIAS_LEN: assert property ($rose(vco_cal_o) |->
    bias_cnt == 12'h320) else $error("bias length");
  AST_LOOP_LEN: assert property ($rose(synth_locked_o) |->
    loop_cnt == 12'hfa0) else $error("loop length");
  AST_HALVE: assert property (halve_output_o != high_band_o)
    else $error("halving");
  AST_TICK: assert property (ref_tick_o |=> !ref_tick_o [*3]
    ##1 ref_tick_o) else $error("tick period");
  AST_DIV_HOLD: assert property (!$past(ref_tick_o) |->
    $stable(frac_value_o) && $stable(int_ratio_o)) else $error("div moved");
  // The modulator may only move the ratio by -3 to +4 around the integer.
  AST_DIV_STEP: assert property ((8'(div_ratio_o) + 8'h03 -
    8'(int_ratio_o)) <= 8'h07) else $error("modulator step");

  // Main scenarios reached.
  cover property ($rose(synth_locked_o));
  cover property ($rose(synth_enable_i) && fast_turn_i);
  cover property (synth_enable_i && freq_wr && synth_locked_o);
  cover property (div_ratio_o != int_ratio_o);
endmodule // synth_frequency_control_chk

bind synth_frequency_control synth_frequency_control_chk i_chk (
  .clk_i, .rst_i, .reg_write_i, .reg_addr_i, .synth_enable_i, .fast_turn_i,
  .bias_settle_phase_o, .vco_cal_o, .loop_settle_phase_o, .synth_locked_o,
  .ref_tick_o, .int_ratio_o, .frac_value_o, .div_ratio_o, .high_band_o,
  .halve_output_o);

// ### verif/host_model.sv
// Host controller model driving the byte register port and target mode.
// Assumes the bench calls its tasks; lines change at falling edges.
`timescale 1ns/1ps

module host_model (
  // Clock.
  input  wire logic       clk_i,
  // Register port and target mode towards the device.
  output logic            reg_write_o,
  output logic            reg_read_o,
  output logic      [6:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            synth_enable_o
);
  // Idle port at time zero.
  initial begin
    reg_write_o = 1'b0;
    reg_read_o = 1'b0;
    reg_addr_o = 7'h00;
    reg_wdata_o = 8'h00;
    synth_enable_o = 1'b0;
  end

  // One strobed byte; released lines are scrambled so stale use shows.
  task automatic access(input logic w, input logic [6:0] a,
                        input logic [7:0] d);
    @(negedge clk_i);
    reg_write_o = w;
    reg_read_o = !w;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(negedge clk_i);
    reg_write_o = 1'b0;
    reg_read_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask

  task automatic set_target(input logic on);
    synth_enable_o = on;
  endtask
endmodule // host_model

// ### verif/synth_frequency_control_tb.sv
// Self-checking bench for the synthesizer frequency control block.
// Assumes the host model and the bench drive inputs at falling edges.
`timescale 1ns/1ps

module synth_frequency_control_tb;
  import synth_freq_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        fast = 1'b0, fsk = 1'b0, txd = 1'b0;
  logic  [8:0] dev = 9'h000;
  logic        wr, rd, en, tick, hb, halve;
  logic  [6:0] addr, iratio;
  logic  [7:0] wdata, rdata;
  logic [15:0] frac;
  wire   [3:0] ph;          // Bias, calibration, loop, locked.
  logic  [7:0] exp_q[$];    // Expected read data, oldest first.
  logic        rd_seen = 1'b0;
  int          errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  logic [31:0] seed = 32'h53e2;
  logic  [6:0] fa[4] = '{7'h73, 7'h74, 7'h76, 7'h77};
  logic  [7:0] rv[5] = '{RST_OFFSET_LOW, RST_OFFSET_HIGH, RST_BAND_SELECT,
                         RST_FRACTION_HIGH, RST_FRACTION_LOW};

  synth_frequency_control i_dut (
    .clk_i, .rst_i, .reg_write_i(wr), .reg_read_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .synth_enable_i(en), .fast_turn_i(fast), .fsk_enable_i(fsk),
    .tx_data_i(txd), .deviation_word_i(dev),
    .bias_settle_phase_o(ph[3]), .vco_cal_o(ph[2]),
    .loop_settle_phase_o(ph[1]), .synth_locked_o(ph[0]),
    .ref_tick_o(tick), .int_ratio_o(iratio), .frac_value_o(frac),
    .div_ratio_o(), .high_band_o(hb), .halve_output_o(halve));
  host_model i_host (.clk_i, .reg_write_o(wr), .reg_read_o(rd),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .synth_enable_o(en));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic end_of_test;
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Read data lands one edge after the strobe; compare against the note.
  always @(posedge clk_i) begin
    rd_seen <= rd;
    cycles++;
    if (cycles == 40000) begin
      errors++;
      end_of_test();
    end
  end
  always @(negedge clk_i) begin
    if (rd_seen) check(16'(rdata), 16'(exp_q.pop_front()), "read");
  end

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.access(1'b0, a, 8'h00);
  endtask

  // Divider outputs follow a tick, which comes every fourth clock.
  task automatic div_chk(input logic [6:0] ei, input logic [15:0] ef);
    repeat (12) @(negedge clk_i);
    check(16'(iratio), 16'(ei), "int ratio");
    check(frac, ef, "fraction");
  endtask

  task automatic seq_run(input int eb, input int ec, input int el);
    int n[4] = '{0, 0, 0, 0};
    for (int k = 0; k < 9000 && ph[0] !== 1'b1; k++) begin
      @(negedge clk_i);
      for (int j = 1; j < 4; j++) n[j] += (ph[j] === 1'b1);
    end
    check(16'(n[3]), 16'(eb), "bias cycles");
    check(16'(n[2]), 16'(ec), "cal cycles");
    check(16'(n[1]), 16'(el), "loop cycles");
    check(16'(ph[0]), 16'h0001, "locked");
  endtask

  initial begin
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    div_chk(7'h2d, 16'hbb80);
    for (int i = 0; i < 5; i++) rd_chk(fa[0] + 7'(i), rv[i]);
    rd_chk(7'h72, 8'h00);
    i_host.access(1'b1, ADDR_BAND_SELECT, 8'hd8);
    rd_chk(ADDR_BAND_SELECT, 8'hd7);
    check(16'({hb, halve}), 16'h0001, "low band");
    i_host.access(1'b1, ADDR_BAND_SELECT, 8'h17);
    rd_chk(ADDR_BAND_SELECT, 8'h17);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      i_host.access(1'b1, fa[seed[9:8]], seed[7:0]);
      rd_chk(fa[seed[9:8]], seed[7:0]);
    end
    i_host.access(1'b1, ADDR_OFFSET_LOW, 8'h00);
    i_host.access(1'b1, ADDR_OFFSET_HIGH, 8'h00);
    i_host.access(1'b1, ADDR_BAND_SELECT, 8'h05);
    i_host.access(1'b1, ADDR_FRACTION_HIGH, 8'h12);
    i_host.access(1'b1, ADDR_FRACTION_LOW, 8'h34);
    div_chk(7'h1d, 16'h1234);
    i_host.access(1'b1, ADDR_OFFSET_LOW, 8'hff);
    i_host.access(1'b1, ADDR_OFFSET_HIGH, 8'h03);
    i_host.access(1'b1, ADDR_FRACTION_HIGH, 8'h00);
    i_host.access(1'b1, ADDR_FRACTION_LOW, 8'h00);
    div_chk(7'h1c, 16'hf9ff);
    // A positive offset of 511 steps lands in the fraction as is.
    i_host.access(1'b1, ADDR_OFFSET_HIGH, 8'h01);
    div_chk(7'h1d, 16'h01ff);
    i_host.access(1'b1, ADDR_OFFSET_LOW, 8'h00);
    i_host.access(1'b1, ADDR_OFFSET_HIGH, 8'h00);
    i_host.access(1'b1, ADDR_FRACTION_HIGH, 8'h10);
    seed = lfsr(seed);
    dev = seed[8:0];
    fsk = 1'b1;
    txd = 1'b1;
    div_chk(7'h1d, 16'h1000 + {5'h00, dev, 2'b00});
    txd = 1'b0;
    div_chk(7'h1d, 16'h1000 - {5'h00, dev, 2'b00});
    i_host.access(1'b1, ADDR_BAND_SELECT, 8'h25);
    div_chk(7'h1d, 16'h1000 - {6'h00, dev, 1'b0});
    check(16'({hb, halve}), 16'h0002, "high band");
    i_host.set_target(1'b1);
    seq_run(800, 3200, 4000);
    i_host.access(1'b1, ADDR_FRACTION_LOW, 8'h55);
    seq_run(799, 3200, 4000);
    i_host.set_target(1'b0);
    @(negedge clk_i);
    fast = 1'b1;
    i_host.set_target(1'b1);
    seq_run(0, 0, 4000);
    end_of_test();
  end
endmodule // synth_frequency_control_tb
